// ===== rtl/key_scan_pkg.sv
package key_scan_pkg;
    // ----------------------------------------
    // Matrix geometry
    // ----------------------------------------
    localparam int ROWS = 8;
    localparam int COLS = 8;
    localparam int KEYS = ROWS * COLS;
    localparam int ROW_W = 3;
    localparam int COL_W = 3;
    localparam int KEY_W = 6;
    localparam int BL_W = 7;
    localparam logic [BL_W-1:0] BURST_MAX = 7'h40;

    // ----------------------------------------
    // Timing (clock 20 MHz, 50 ns)
    // ----------------------------------------
    localparam int CLK_NS = 50;
    localparam int DWELL_NS = 167;
    localparam int PULSE_MIN_NS = 2000;
    localparam int PULSE_MAX_NS = 10000;
    localparam int BURST_MIN_NS = 250000;
    localparam int BURST_MAX_NS = 2000000;
    localparam int SETUP_CYC = 1;
    localparam int DWELL_CYC = (DWELL_NS / CLK_NS) < 1 ? 1 : (DWELL_NS / CLK_NS);
    localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_NS;
    localparam int BURST_MIN_CYC = (BURST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int BURST_MAX_CYC = BURST_MAX_NS / CLK_NS;
    localparam int PCNT_W = 8;
    localparam int BCNT_W = 16;
    localparam logic [PCNT_W-1:0] PULSE_DEF = 8'h50;
    localparam logic [BCNT_W-1:0] BURST_DEF = 16'h1388;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_HIGH = 3'b011,
        ST_LOW = 3'b010,
        ST_WAIT = 3'b110
    } phase_type;

    typedef struct packed {
        logic [ROWS-1:0] row_drive;
        logic [COLS-1:0] column_gate_select;
        logic [COL_W-1:0] column_mux_code;
        logic gate_timer_trigger;
    } drive_type;

    typedef struct packed {
        logic [KEY_W-1:0] key;
        logic [BL_W-1:0] left;
        logic [PCNT_W-1:0] pcnt;
        logic [BCNT_W-1:0] bcnt;
        logic [KEY_W-1:0] wkey;
        logic [BL_W-1:0] wval;
        logic we;
        logic key_done;
        phase_type phase;
        drive_type drv;
    } state_type;
endpackage : key_scan_pkg

// ===== rtl/key_matrix_scan_drive.sv
module key_matrix_scan_drive
    import key_scan_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic scan_enable,
    input wire logic [PCNT_W-1:0] pulse_spacing_cycles,
    input wire logic [BCNT_W-1:0] burst_spacing_cycles,
    // Burst length table write
    input wire logic bl_write,
    input wire logic [KEY_W-1:0] bl_key,
    input wire logic [BL_W-1:0] bl_value,
    // Matrix side
    output logic [ROWS-1:0] row_drive,
    output logic [COLS-1:0] column_gate_select,
    output logic [COL_W-1:0] column_mux_code,
    output logic gate_timer_trigger,
    output logic burst_done
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [PCNT_W-1:0] clamp_pulse(input logic [PCNT_W-1:0] v);
        if (v < PCNT_W'(PULSE_MIN_CYC)) begin
            return PCNT_W'(PULSE_MIN_CYC);
        end else if (v > PCNT_W'(PULSE_MAX_CYC)) begin
            return PCNT_W'(PULSE_MAX_CYC);
        end
        return v;
    endfunction : clamp_pulse

    function automatic logic [BCNT_W-1:0] clamp_burst(input logic [BCNT_W-1:0] v);
        if (v < BCNT_W'(BURST_MIN_CYC)) begin
            return BCNT_W'(BURST_MIN_CYC);
        end else if (v > BCNT_W'(BURST_MAX_CYC)) begin
            return BCNT_W'(BURST_MAX_CYC);
        end
        return v;
    endfunction : clamp_burst

    function automatic logic bl_legal(input logic [BL_W-1:0] v);
        return v <= BURST_MAX;
    endfunction : bl_legal

    // ----------------------------------------
    // Burst length table and state
    // ----------------------------------------
    logic [BL_W-1:0] bl_mem [KEYS];
    logic [BL_W-1:0] bl_rd;
    state_type s_r;
    state_type s_nxt;

    // Reset leaves every key at zero, so no pulses until software loads a table
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < KEYS; i++) begin
                bl_mem[i] <= '0;
            end
        end else if (s_r.we) begin
            bl_mem[s_r.wkey] <= s_r.wval;
        end
    end

    assign bl_rd = bl_mem[s_r.key];

    always_comb begin
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        row = s_r.key[ROW_W-1:0];
        col = s_r.key[KEY_W-1:ROW_W];
        s_nxt = s_r;
        s_nxt.we = bl_write && bl_legal(bl_value);
        s_nxt.wkey = bl_key;
        s_nxt.wval = bl_value;
        s_nxt.key_done = 1'b0;
        if (s_r.bcnt != '0) begin
            s_nxt.bcnt = s_r.bcnt - 1'b1;
        end
        if (s_r.pcnt != '0) begin
            s_nxt.pcnt = s_r.pcnt - 1'b1;
        end
        case (s_r.phase)
            ST_IDLE: begin
                s_nxt.drv = '0;
                if (scan_enable) begin
                    // Start and idle cycles belong to the slot, so start-to-start is exact while the burst fits in the slot
                    s_nxt.bcnt = clamp_burst(burst_spacing_cycles) - BCNT_W'(2);
                    s_nxt.left = bl_rd;
                    if (bl_rd == '0) begin
                        s_nxt.phase = ST_WAIT;
                    end else begin
                        // Select column first so code is settled ahead of trigger
                        s_nxt.drv.column_gate_select = COLS'(1) << col;
                        s_nxt.drv.column_mux_code = col;
                        s_nxt.pcnt = PCNT_W'(SETUP_CYC);
                        s_nxt.phase = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                if (s_r.pcnt <= 8'h01) begin
                    s_nxt.drv.gate_timer_trigger = 1'b1;
                    s_nxt.drv.row_drive = ROWS'(1) << row;
                    s_nxt.pcnt = PCNT_W'(DWELL_CYC);
                    s_nxt.phase = ST_HIGH;
                end
            end
            ST_HIGH: begin
                // Trigger drops after the dwell; row stays high one more cycle
                if (s_r.pcnt == 8'h01) begin
                    s_nxt.drv.gate_timer_trigger = 1'b0;
                end
                if (s_r.pcnt == '0) begin
                    s_nxt.drv.row_drive = '0;
                    s_nxt.left = s_r.left - 1'b1;
                    // High, low and setup cycles together make one pulse period
                    s_nxt.pcnt = clamp_pulse(pulse_spacing_cycles) -
                        PCNT_W'(DWELL_CYC + SETUP_CYC + 2);
                    s_nxt.phase = ST_LOW;
                end
            end
            ST_LOW: begin
                if (s_r.pcnt == '0) begin
                    if (s_r.left == '0) begin
                        s_nxt.drv = '0;
                        s_nxt.phase = ST_WAIT;
                    end else begin
                        s_nxt.pcnt = PCNT_W'(SETUP_CYC);
                        s_nxt.phase = ST_SETUP;
                    end
                end
            end
            ST_WAIT: begin
                s_nxt.drv = '0;
                if (s_r.bcnt == '0) begin
                    s_nxt.key_done = 1'b1;
                    s_nxt.key = s_r.key + 1'b1;
                    s_nxt.phase = ST_IDLE;
                end
            end
            default: begin
                s_nxt.phase = ST_IDLE;
                s_nxt.drv = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '{phase: ST_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs straight from state flops
    // ----------------------------------------
    assign row_drive = s_r.drv.row_drive;
    assign column_gate_select = s_r.drv.column_gate_select;
    assign column_mux_code = s_r.drv.column_mux_code;
    assign gate_timer_trigger = s_r.drv.gate_timer_trigger;
    assign burst_done = s_r.key_done;

endmodule : key_matrix_scan_drive

// ===== verification/clamp_gate_model.sv
module clamp_gate_model
    import key_scan_pkg::*;
(
    // From the scan block
    input wire logic [ROWS-1:0] row_drive,
    input wire logic [COLS-1:0] column_gate_select,
    input wire logic gate_timer_trigger,
    // Clamp lines (high grounds a column) and mux enable
    output logic [COLS-1:0] column_clamp,
    output logic sampler_enable_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic any_row;
    logic row_late;
    // ----------------------------------------
    // Timing network, a fixed delay stands in for the RC
    // ----------------------------------------
    assign any_row = (|row_drive[ROWS-2:0]) | row_drive[ROWS-1];
    always @(any_row) row_late <= #75 any_row;
    assign sampler_enable_pulse = ~(gate_timer_trigger & ~row_late);
    // Ground all columns whenever the mux is off
    assign column_clamp = sampler_enable_pulse ? '1 : ~column_gate_select;
endmodule : clamp_gate_model

// ===== verification/key_scan_properties.sv
module key_scan_checker
    import key_scan_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Block outputs
    input wire logic [ROWS-1:0] row_drive,
    input wire logic [COLS-1:0] column_gate_select,
    input wire logic [COL_W-1:0] column_mux_code,
    input wire logic gate_timer_trigger,
    input wire logic burst_done
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_row_onehot: assert property ($onehot0(row_drive)) else $error("two rows");
    chk_sel_onehot: assert property ($onehot0(column_gate_select)) else $error("two cols");
    chk_code_match: assert property (|column_gate_select |->
        column_gate_select == (8'h01 << column_mux_code)) else $error("code mismatch");
    chk_row_has_col: assert property (|row_drive |-> $onehot(column_gate_select)
        && $stable(column_mux_code)) else $error("row without column");
    chk_trig_at_rise: assert property ($rose(|row_drive) |-> $rose(gate_timer_trigger))
        else $error("trigger not with row");
    chk_trig_width: assert property ($rose(gate_timer_trigger) |->
        gate_timer_trigger[*3] ##1 !gate_timer_trigger) else $error("dwell width");
    chk_trig_before_fall: assert property ($fell(|row_drive) |-> !$past(gate_timer_trigger))
        else $error("trigger at row fall");
    chk_row_width: assert property ($rose(|row_drive) |->
        (|row_drive)[*4] ##1 !(|row_drive)) else $error("row width");
    chk_pulse_gap: assert property ($fell(|row_drive) |-> !(|row_drive)[*8])
        else $error("pulse gap short");
    chk_done_quiet: assert property (burst_done |-> row_drive == 0 &&
        column_gate_select == 0 && !gate_timer_trigger) else $error("row at slot end");
endmodule : key_scan_checker
bind key_matrix_scan_drive key_scan_checker u_chk (.mclk(mclk), .rst(rst),
    .row_drive(row_drive),
    .column_gate_select(column_gate_select), .column_mux_code(column_mux_code),
    .gate_timer_trigger(gate_timer_trigger), .burst_done(burst_done));

// ===== verification/test_key_matrix_scan_drive.sv
module test_key_matrix_scan_drive
    import key_scan_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, scan_enable = 0, bl_write = 0;
    logic [PCNT_W-1:0] pulse_spacing_cycles = '0;
    logic [BCNT_W-1:0] burst_spacing_cycles = '0;
    logic [KEY_W-1:0] bl_key = '0;
    logic [BL_W-1:0] bl_value = '0;
    logic [ROWS-1:0] row_drive;
    logic [COLS-1:0] column_gate_select, column_clamp;
    logic [COL_W-1:0] column_mux_code;
    logic gate_timer_trigger, burst_done, sampler_enable_pulse;
    int n_mismatch = 0;
    int checks_done = 0;
    key_matrix_scan_drive dut_u (.mclk(mclk), .rst(rst), .scan_enable(scan_enable),
        .pulse_spacing_cycles(pulse_spacing_cycles), .burst_spacing_cycles(burst_spacing_cycles),
        .bl_write(bl_write), .bl_key(bl_key), .bl_value(bl_value), .row_drive(row_drive),
        .column_gate_select(column_gate_select),
        .column_mux_code(column_mux_code), .gate_timer_trigger(gate_timer_trigger),
        .burst_done(burst_done));
    clamp_gate_model pld_u (.row_drive(row_drive), .column_gate_select(column_gate_select),
        .gate_timer_trigger(gate_timer_trigger), .column_clamp(column_clamp),
        .sampler_enable_pulse(sampler_enable_pulse));
    initial begin
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [KEY_W-1:0] k, input logic [BL_W-1:0] v);
        bl_key = k;
        bl_value = v;
        bl_write = 1;
        @(negedge mclk);
        bl_write = 0;
        @(negedge mclk);
    endtask : wr
    // ----------------------------------------
    // One key slot: count pulses, spacing, slot length
    // ----------------------------------------
    task automatic slot(input int row, input int col, input int n, input int sp, input bit gap_chk);
        int t;
        int cnt;
        int last;
        logic [ROWS-1:0] prev;
        cnt = 0;
        last = -1;
        prev = '0;
        for (t = 1; t <= 6000; t++) begin
            @(negedge mclk);
            if (row_drive !== 8'h00 && prev === 8'h00) begin
                chk(16'(row_drive), 16'h0001 << row);
                chk(16'(column_gate_select), 16'h0001 << col);
                chk(16'(column_mux_code), 16'(col));
                chk(16'(column_clamp), 16'(8'hff ^ (8'h01 << col)));
                chk(16'(gate_timer_trigger), 16'h0001);
                if (last >= 0) chk(16'(t - last), 16'(sp));
                last = t;
                cnt++;
            end
            prev = row_drive;
            if (burst_done === 1'b1) break;
        end
        if (t > 6000) begin
            n_mismatch++;
            final_report();
        end
        chk(16'(cnt), 16'(n));
        // Short spacing input clamps to 5000 cycles start to start
        if (gap_chk) chk(16'(t), 16'h1388);
    endtask : slot
    task automatic scn_reset();
        repeat (8) @(negedge mclk);
        rst = 0;
        chk({row_drive, column_gate_select}, 16'h0000);
        wr(6'h00, 7'h03);
        wr(6'h02, 7'h40);
        wr(6'h03, 7'h41);
        wr(6'h08, 7'h02);
        pulse_spacing_cycles = 8'hff;
        scan_enable = 1;
    endtask : scn_reset
    task automatic scn_long_spacing();
        slot(0, 0, 3, 200, 0);
        pulse_spacing_cycles = 8'h0a;
    endtask : scn_long_spacing
    task automatic scn_zero_len();
        slot(1, 0, 0, 40, 1);
    endtask : scn_zero_len
    task automatic scn_full_burst();
        slot(2, 0, 64, 40, 1);
    endtask : scn_full_burst
    task automatic scn_refused();
        slot(3, 0, 0, 40, 1);
    endtask : scn_refused
    task automatic scn_next_column();
        for (int k = 4; k < 8; k++) begin
            slot(k, 0, 0, 40, 1);
        end
        slot(0, 1, 2, 40, 1);
    endtask : scn_next_column
    initial begin
        scn_reset();
        scn_long_spacing();
        scn_zero_len();
        scn_full_burst();
        scn_refused();
        scn_next_column();
        final_report();
    end
endmodule : test_key_matrix_scan_drive
